//--- hdl/swu_top.v
// Purpose: setpoint waveform unit of a programmable DC supply
// Assumes: controller pulses are one clock wide, all inputs synchronous
// Notes:   one set value per 0.1 ms tick; ramps by serial division
// Operation
// - load switches output on, static values applied
// - current target starts from zero amperes
// - start only after load, with output on or off
// - start with output off turns it on
// - stop halts waveform, output stays on
// - on/off while running halts and disables output
// - alarm or trip aborts, disables, flags alarm
// - sine uses fixed 1 to 10000 Hz
// - triangle rises over t1, falls over t2
// - offset from foot, top saturates at nominal
// - rectangle upper for t1, offset for t2
// - trapezoid rise, top, fall, base phases
// - engine curve voltage only, five linear ramps
// - engine segments reset to standard defaults
// - engine repeats 1 to 999, zero endless
// - pause after each pass except the last
// - engine hold voltage before/after, limits fixed
// - configuration accepted only with output off
// - unavailable in resistance or slave mode
`include "swu_defines.vh"
module swu_top #(
    parameter TICK_CYCLES = `SWU_TICK_CYCLES
) (
    input  wire         ref_clk_in,
    input  wire         sys_rst_in,
    input  wire         load_in,
    input  wire         start_in,
    input  wire         stop_in,
    input  wire         onoff_in,
    input  wire         alarm_clr_in,
    input  wire [2:0]   func_sel_in,
    input  wire         target_current_in,
    input  wire [15:0]  amplitude_in,
    input  wire [15:0]  offset_in,
    input  wire [13:0]  frequency_in,
    input  wire [28:0]  first_phase_time_in,
    input  wire [28:0]  second_phase_time_in,
    input  wire [28:0]  third_phase_time_in,
    input  wire [28:0]  fourth_phase_time_in,
    input  wire [9:0]   cycles_in,
    input  wire [15:0]  hold_volt_in,
    input  wire         seg_wr_in,
    input  wire [2:0]   seg_addr_in,
    input  wire [15:0]  seg_start_in,
    input  wire [15:0]  seg_end_in,
    input  wire [28:0]  seg_time_in,
    input  wire [15:0]  static_volt_in,
    input  wire [15:0]  curr_limit_in,
    input  wire [15:0]  pow_limit_in,
    input  wire [15:0]  gen_limit_in,
    input  wire         resistance_mode_in,
    input  wire         slave_mode_in,
    input  wire         unit_alarm_in,
    input  wire         power_limit_trip_in,
    input  wire         current_limit_trip_in,
    input  wire         event_alarm_in,
    output reg          dc_on_out,
    output reg  [15:0]  volt_set_out,
    output reg  [15:0]  curr_set_out,
    output reg  [15:0]  pow_set_out,
    output wire         loaded_out,
    output wire         running_out,
    output wire         start_enable_out,
    output reg          alarm_out,
    output wire         available_out
);

    localparam ST_IDLE  = 3'b001;
    localparam ST_READY = 3'b010;
    localparam ST_RUN   = 3'b100;

    reg [2:0]  state;
    reg [2:0]  fn;
    reg        tgt_cur;
    reg [15:0] amp;
    reg [15:0] offs;
    reg [13:0] freq;
    reg [28:0] tm1;
    reg [28:0] tm2;
    reg [28:0] tm3;
    reg [28:0] tm4;
    reg [9:0]  cyc;
    reg [15:0] hold;
    reg [2:0]  ph;
    reg [28:0] el;
    reg [31:0] acc;
    reg [9:0]  pass_cnt;
    reg [15:0] gen;
    reg [1:0]  tk_d;
    reg        dv_busy;
    reg [5:0]  dv_cnt;
    reg [44:0] dv_num;
    reg [28:0] dv_den;
    reg [28:0] dv_rem;
    reg [15:0] dv_quo;
    reg [15:0] dv_sv;
    reg        dv_down;
    reg [15:0] p_sv;
    reg [15:0] p_ev;
    reg [28:0] p_t;
    reg [2:0]  p_last;

    wire        tick;
    wire [60:0] seg_rd;
    wire fault = unit_alarm_in | power_limit_trip_in |
                 current_limit_trip_in | event_alarm_in;
    wire avail = !resistance_mode_in && !slave_mode_in;
    wire run   = (state == ST_RUN);
    wire do_load = load_in && !dc_on_out && avail && !fault &&
                   (state != ST_RUN);
    wire do_start = (state == ST_READY) && start_in && avail
                    && !fault;

    assign loaded_out       = (state != ST_IDLE);
    assign running_out      = run;
    assign start_enable_out = (state == ST_READY) && avail && !fault;
    assign available_out    = avail;

    swu_tick_div #(
        .CYCLES (TICK_CYCLES),
        .W      (32)
    ) u_tick (
        .ref_clk_in (ref_clk_in),
        .sys_rst_in (sys_rst_in),
        .en_in      (run),
        .tick_out   (tick)
    );

    swu_seg_mem u_seg (
        .ref_clk_in  (ref_clk_in),
        .sys_rst_in  (sys_rst_in),
        .wr_en_in    (seg_wr_in && !dc_on_out && avail),
        .wr_addr_in  (seg_addr_in),
        .wr_data_in  ({seg_start_in, seg_end_in, seg_time_in}),
        .rd_addr_in  (ph),
        .rd_data_out (seg_rd)
    );

    function [28:0] clamp_t;
        input [28:0] t;
        begin
            if (t < `SWU_TIME_MIN)
                clamp_t = `SWU_TIME_MIN;
            else if (t > `SWU_TIME_MAX)
                clamp_t = `SWU_TIME_MAX;
            else
                clamp_t = t;
        end
    endfunction

    // upper level saturates at full scale
    wire [16:0] tsum    = {1'b0, offs} + {1'b0, amp};
    wire [15:0] top_lvl = tsum[16] ? 16'hffff : tsum[15:0];

    // sine by parabolic half-wave approximation
    wire [32:0] phase_full = freq * `SWU_SINE_INC_PER_HZ;
    wire [31:0] phase_inc  = phase_full[31:0];
    wire [14:0] sx    = acc[30:16];
    wire [30:0] spar  = sx * (16'h8000 - {1'b0, sx});
    wire [15:0] sy    = spar[28:13];
    wire [31:0] samp  = amp * sy;
    wire [15:0] sdev  = samp[30:15];
    wire [16:0] sup   = {1'b0, offs} + {1'b0, sdev};
    wire [15:0] sine_val = acc[31] ?
                           ((offs > sdev) ? offs - sdev : 16'h0000) :
                           (sup[16] ? 16'hffff : sup[15:0]);

    // level pair and duration of the current phase
    always @* begin
        p_sv   = offs;
        p_ev   = offs;
        p_t    = tm1;
        p_last = 3'h1;
        case (fn)
            `SWU_FN_TRIANGLE: begin
                p_sv = ph[0] ? top_lvl : offs;
                p_ev = ph[0] ? offs : top_lvl;
                p_t  = ph[0] ? tm2 : tm1;
            end
            `SWU_FN_RECTANGLE: begin
                p_sv = ph[0] ? offs : top_lvl;
                p_ev = p_sv;
                p_t  = ph[0] ? tm2 : tm1;
            end
            `SWU_FN_TRAPEZOID: begin
                p_last = 3'h3;
                case (ph[1:0])
                    2'h0: begin
                        p_ev = top_lvl;
                    end
                    2'h1: begin
                        p_sv = top_lvl;
                        p_ev = top_lvl;
                        p_t  = tm2;
                    end
                    2'h2: begin
                        p_sv = top_lvl;
                        p_t  = tm3;
                    end
                    default: begin
                        p_t  = tm4;
                    end
                endcase
            end
            `SWU_FN_ENGINE: begin
                p_last = `SWU_PAUSE_PHASE;
                if (ph == `SWU_PAUSE_PHASE) begin
                    p_sv = hold;
                    p_ev = hold;
                    p_t  = tm1;
                end else begin
                    p_sv = seg_rd[60:45];
                    p_ev = seg_rd[44:29];
                    p_t  = clamp_t(seg_rd[28:0]);
                end
            end
            default: begin
                p_t = tm1;
            end
        endcase
    end

    wire        p_down = (p_ev < p_sv);
    wire [15:0] p_diff = p_down ? p_sv - p_ev : p_ev - p_sv;
    wire        ph_end = (el + 29'h0000001) >= p_t;
    wire [9:0]  pass_nx = pass_cnt + 10'h001;
    wire        eng_done = (cyc == `SWU_CYCLES_ONE) ||
                           ((cyc != 10'h000) && (pass_nx == cyc));

    // configuration latched on load only
    always @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
            fn      <= `SWU_FN_SINE;
            tgt_cur <= 1'b0;
            amp     <= 16'h0000;
            offs    <= 16'h0000;
            freq    <= `SWU_SINE_FREQ_MIN;
            tm1     <= `SWU_TIME_MIN;
            tm2     <= `SWU_TIME_MIN;
            tm3     <= `SWU_TIME_MIN;
            tm4     <= `SWU_TIME_MIN;
            cyc     <= `SWU_CYCLES_ONE;
            hold    <= 16'h0000;
        end else if (do_load) begin
            fn      <= (func_sel_in > `SWU_FN_ENGINE) ?
                       `SWU_FN_SINE : func_sel_in;
            tgt_cur <= target_current_in &&
                       (func_sel_in != `SWU_FN_ENGINE);
            amp     <= amplitude_in;
            offs    <= offset_in;
            if (frequency_in < `SWU_SINE_FREQ_MIN)
                freq <= `SWU_SINE_FREQ_MIN;
            else if (frequency_in > `SWU_SINE_FREQ_MAX)
                freq <= `SWU_SINE_FREQ_MAX;
            else
                freq <= frequency_in;
            tm1     <= clamp_t(first_phase_time_in);
            tm2     <= clamp_t(second_phase_time_in);
            tm3     <= clamp_t(third_phase_time_in);
            tm4     <= clamp_t(fourth_phase_time_in);
            cyc     <= (cycles_in > `SWU_CYCLES_MAX) ?
                       `SWU_CYCLES_MAX : cycles_in;
            hold    <= hold_volt_in;
        end
    end

    // control state, output switch, phase sequencing
    always @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
            state     <= ST_IDLE;
            dc_on_out <= 1'b0;
            alarm_out <= 1'b0;
            ph        <= 3'h0;
            el        <= 29'h0;
            acc       <= 32'h0;
            pass_cnt  <= 10'h000;
        end else begin
            alarm_out <= fault | (alarm_out & ~alarm_clr_in);
            if (fault) begin
                dc_on_out <= 1'b0;
                if (!avail)
                    state <= ST_IDLE;
                else if (state != ST_IDLE)
                    state <= ST_READY;
            end else if (!avail) begin
                state <= ST_IDLE;
                if (onoff_in)
                    dc_on_out <= ~dc_on_out;
            end else begin
                case (state)
                    ST_IDLE: begin
                        if (do_load) begin
                            state     <= ST_READY;
                            dc_on_out <= 1'b1;
                        end else if (onoff_in) begin
                            dc_on_out <= ~dc_on_out;
                        end
                    end
                    ST_READY: begin
                        if (do_start) begin
                            state     <= ST_RUN;
                            dc_on_out <= 1'b1;
                            ph        <= 3'h0;
                            el        <= 29'h0;
                            acc       <= 32'h0;
                            pass_cnt  <= 10'h000;
                        end else if (do_load) begin
                            dc_on_out <= 1'b1;
                        end else if (onoff_in) begin
                            dc_on_out <= ~dc_on_out;
                        end
                    end
                    ST_RUN: begin
                        if (onoff_in) begin
                            state     <= ST_READY;
                            dc_on_out <= 1'b0;
                        end else if (stop_in) begin
                            state     <= ST_READY;
                        end else if (tick) begin
                            acc <= acc + phase_inc;
                            if (fn != `SWU_FN_SINE && ph_end) begin
                                el <= 29'h0;
                                if (fn == `SWU_FN_ENGINE &&
                                    ph == `SWU_SEG_LAST) begin
                                    pass_cnt <= pass_nx;
                                    if (eng_done)
                                        state <= ST_READY;
                                    else
                                        ph <= `SWU_PAUSE_PHASE;
                                end else if (ph == p_last) begin
                                    ph <= 3'h0;
                                end else begin
                                    ph <= ph + 3'h1;
                                end
                            end else begin
                                el <= el + 29'h0000001;
                            end
                        end
                    end
                    default: begin
                        state <= ST_IDLE;
                    end
                endcase
            end
        end
    end

    // ramp interpolation: sv +/- diff * el / t, one bit per clock
    wire [29:0] dv_sh = {dv_rem, dv_num[44]};
    wire        dv_ge = dv_sh >= {1'b0, dv_den};
    wire [29:0] dv_sub = dv_sh - {1'b0, dv_den};

    always @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
            tk_d    <= 2'b00;
            dv_busy <= 1'b0;
            dv_cnt  <= 6'h00;
            dv_num  <= 45'h0;
            dv_den  <= `SWU_TIME_MIN;
            dv_rem  <= 29'h0;
            dv_quo  <= 16'h0000;
            dv_sv   <= 16'h0000;
            dv_down <= 1'b0;
            gen     <= 16'h0000;
        end else begin
            // start computes the first phase value at once
            tk_d <= {tk_d[0], (tick & run) | do_start};
            if (tk_d[1] && run) begin
                if (fn == `SWU_FN_SINE) begin
                    gen <= sine_val;
                end else begin
                    dv_num  <= p_diff * el;
                    dv_den  <= p_t;
                    dv_rem  <= 29'h0;
                    dv_quo  <= 16'h0000;
                    dv_sv   <= p_sv;
                    dv_down <= p_down;
                    dv_cnt  <= 6'h2d;
                    dv_busy <= 1'b1;
                end
            end else if (dv_busy) begin
                if (dv_cnt != 6'h00) begin
                    dv_num <= {dv_num[43:0], 1'b0};
                    dv_rem <= dv_ge ? dv_sub[28:0] : dv_sh[28:0];
                    dv_quo <= {dv_quo[14:0], dv_ge};
                    dv_cnt <= dv_cnt - 6'h01;
                end else begin
                    dv_busy <= 1'b0;
                    gen <= dv_down ? dv_sv - dv_quo : dv_sv + dv_quo;
                end
            end
        end
    end

    // set values toward the power stage
    wire [15:0] stat_v = (fn == `SWU_FN_ENGINE && loaded_out) ?
                         hold : static_volt_in;
    wire [15:0] gen_c  = (gen > gen_limit_in) ? gen_limit_in : gen;

    always @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
            volt_set_out <= 16'h0000;
            curr_set_out <= 16'h0000;
            pow_set_out  <= 16'h0000;
        end else begin
            volt_set_out <= (run && !tgt_cur) ? gen_c : stat_v;
            if (run && tgt_cur)
                curr_set_out <= gen_c;
            else if (loaded_out && tgt_cur)
                curr_set_out <= 16'h0000;
            else
                curr_set_out <= curr_limit_in;
            pow_set_out  <= pow_limit_in;
        end
    end

endmodule // swu_top

//--- hdl/swu_defines.vh
// Purpose: shared constants of the setpoint waveform unit
// Assumes: 200 MHz clock, 0.1 ms generator tick
// Notes:   times are counts of 0.1 ms ticks, levels are raw set-value codes
`ifndef SWU_DEFINES_VH
`define SWU_DEFINES_VH

`define SWU_CLK_PERIOD_NS   5
`define SWU_TICK_PERIOD_NS  100000
`define SWU_TICK_CYCLES     (`SWU_TICK_PERIOD_NS / `SWU_CLK_PERIOD_NS)

// function selection codes
`define SWU_FN_SINE         3'h0
`define SWU_FN_TRIANGLE     3'h1
`define SWU_FN_RECTANGLE    3'h2
`define SWU_FN_TRAPEZOID    3'h3
`define SWU_FN_ENGINE       3'h4

// sine frequency range in Hz, phase step per Hz at a 10 kHz tick
`define SWU_SINE_FREQ_MIN   14'h0001
`define SWU_SINE_FREQ_MAX   14'h2710
`define SWU_SINE_INC_PER_HZ 19'h68db9

// phase time range: 0.1 ms .. 36000 s in ticks
`define SWU_TIME_MIN        29'h0000001
`define SWU_TIME_MAX        29'h15752a00

// repetition count: 0 endless, 1..999
`define SWU_CYCLES_MAX      10'h3e7
`define SWU_CYCLES_ONE      10'h001

// engine-start segment count, last segment index and index of the pause phase
`define SWU_SEG_COUNT       5
`define SWU_SEG_LAST        3'h4
`define SWU_PAUSE_PHASE     3'h5

// default engine-start segments: start level, end level, ramp ticks
`define SWU_SEG0_START      16'hc000
`define SWU_SEG0_END        16'h4000
`define SWU_SEG0_TIME       29'h0000032
`define SWU_SEG1_START      16'h4000
`define SWU_SEG1_END        16'h4000
`define SWU_SEG1_TIME       29'h00000c8
`define SWU_SEG2_START      16'h4000
`define SWU_SEG2_END        16'h6000
`define SWU_SEG2_TIME       29'h0000064
`define SWU_SEG3_START      16'h6000
`define SWU_SEG3_END        16'h6000
`define SWU_SEG3_TIME       29'h00003e8
`define SWU_SEG4_START      16'h6000
`define SWU_SEG4_END        16'hc000
`define SWU_SEG4_TIME       29'h0000064

`endif

//--- hdl/swu_tick_div.v
// Purpose: 0.1 ms tick enable from the system clock
// Assumes: synchronous active-high reset
// Notes:   counter restarts whenever the enable drops
module swu_tick_div #(
    parameter CYCLES = 20000,
    parameter W      = 16
) (
    input  wire         ref_clk_in,
    input  wire         sys_rst_in,
    input  wire         en_in,
    output reg          tick_out
);

    reg [W-1:0] count;

    always @(posedge ref_clk_in) begin
        if (sys_rst_in || !en_in) begin
            count    <= {W{1'b0}};
            tick_out <= 1'b0;
        end else if (count == CYCLES[W-1:0] - {{(W-1){1'b0}}, 1'b1}) begin
            count    <= {W{1'b0}};
            tick_out <= 1'b1;
        end else begin
            count    <= count + {{(W-1){1'b0}}, 1'b1};
            tick_out <= 1'b0;
        end
    end

endmodule // swu_tick_div

//--- hdl/swu_seg_mem.v
// Purpose: engine-start segment store, five entries
// Assumes: entry = {start level, end level, ramp ticks}
// Notes:   reset reloads the standard curve, read data registered
`include "swu_defines.vh"
module swu_seg_mem (
    input  wire         ref_clk_in,
    input  wire         sys_rst_in,
    input  wire         wr_en_in,
    input  wire [2:0]   wr_addr_in,
    input  wire [60:0]  wr_data_in,
    input  wire [2:0]   rd_addr_in,
    output reg  [60:0]  rd_data_out
);

    reg [60:0] mem [0:`SWU_SEG_COUNT-1];

    always @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
            mem[0] <= {`SWU_SEG0_START, `SWU_SEG0_END, `SWU_SEG0_TIME};
            mem[1] <= {`SWU_SEG1_START, `SWU_SEG1_END, `SWU_SEG1_TIME};
            mem[2] <= {`SWU_SEG2_START, `SWU_SEG2_END, `SWU_SEG2_TIME};
            mem[3] <= {`SWU_SEG3_START, `SWU_SEG3_END, `SWU_SEG3_TIME};
            mem[4] <= {`SWU_SEG4_START, `SWU_SEG4_END, `SWU_SEG4_TIME};
            rd_data_out <= 61'h0;
        end else begin
            if (wr_en_in && wr_addr_in <= `SWU_SEG_LAST)
                mem[wr_addr_in] <= wr_data_in;
            if (rd_addr_in <= `SWU_SEG_LAST)
                rd_data_out <= mem[rd_addr_in];
            else
                rd_data_out <= 61'h0;
        end
    end

endmodule // swu_seg_mem

//--- test/swu_stage.sv
// Purpose: power stage model fed by the voltage set value
// Assumes: stage follows the voltage set value one clock later
// Notes:   an open output shows zero volts
module swu_stage (
    input  logic        clk_in,
    input  logic        dc_on_in,
    input  logic [15:0] volt_in,
    output logic [15:0] volt_out
);
    timeunit 1ns;
    timeprecision 1ps;
    always @(posedge clk_in) volt_out <= dc_on_in ? volt_in : 16'h0000;
endmodule // swu_stage

//--- test/swu_top_asserts.sv
// Purpose: port-level checker of swu_top
// Assumes: one clock domain, synchronous reset
// Notes:   command relations only, waveform shape left to the bench
module swu_top_asserts (
    input logic        ref_clk_in,
    input logic        sys_rst_in,
    input logic        load_in,
    input logic        start_in,
    input logic        stop_in,
    input logic        onoff_in,
    input logic        alarm_clr_in,
    input logic        target_current_in,
    input logic [2:0]  func_sel_in,
    input logic        resistance_mode_in,
    input logic        slave_mode_in,
    input logic        unit_alarm_in,
    input logic        power_limit_trip_in,
    input logic        current_limit_trip_in,
    input logic        event_alarm_in,
    input logic        dc_on_out,
    input logic [15:0] curr_set_out,
    input logic        loaded_out,
    input logic        running_out,
    input logic        alarm_out,
    input logic        available_out
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (sys_rst_in);
    wire flt = unit_alarm_in | power_limit_trip_in | current_limit_trip_in
        | event_alarm_in;
    wire ok = available_out & !flt;
    wire ld = load_in & ok & !dc_on_out & !running_out & !onoff_in;
    a_load_on: assert property (ld |=> dc_on_out && loaded_out)
        else $error("load left output off");
    a_curr_zero: assert property (ld && target_current_in
        && func_sel_in != 3'h4 |-> ##2 curr_set_out == 16'h0000)
        else $error("current target not started at zero");
    a_start_gate: assert property (
        start_in && !loaded_out && !running_out |=> !running_out)
        else $error("start taken without load");
    a_start_auto: assert property (start_in && loaded_out && ok
        && !dc_on_out && !stop_in && !onoff_in |=> running_out && dc_on_out)
        else $error("start did not switch output on");
    a_stop_keep: assert property (running_out && stop_in && !onoff_in
        && ok |=> !running_out && dc_on_out)
        else $error("stop misbehaved");
    a_onoff_halt: assert property (running_out && onoff_in && ok
        |=> !running_out && !dc_on_out)
        else $error("on off did not halt");
    a_fault_abort: assert property (
        flt |=> !dc_on_out && !running_out && alarm_out)
        else $error("fault did not abort");
    a_alarm_hold: assert property (
        alarm_out && !alarm_clr_in |=> $stable(alarm_out))
        else $error("alarm flag dropped");
    a_alarm_clear: assert property (alarm_clr_in && !flt |=> !alarm_out)
        else $error("alarm flag not cleared");
    a_mode_block: assert property (
        resistance_mode_in || slave_mode_in
        |-> !available_out ##1 !running_out && !loaded_out)
        else $error("unit available in blocked mode");
endmodule // swu_top_asserts
bind swu_top swu_top_asserts chk (.*);

//--- test/swu_top_tb.sv
// Purpose: self-checking bench of swu_top
// Assumes: tick shortened to 100 clocks
// Notes:   levels are raw set-value codes
module swu_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam TK = 100;
    logic ref_clk_in = 1'b0, sys_rst_in = 1'b1, load_in, start_in, stop_in;
    logic onoff_in, alarm_clr_in, target_current_in, seg_wr_in;
    logic resistance_mode_in, slave_mode_in, unit_alarm_in, event_alarm_in;
    logic power_limit_trip_in, current_limit_trip_in;
    logic [2:0] func_sel_in = 3'h0, seg_addr_in = 3'h0;
    logic [9:0] cycles_in = 10'h001;
    logic [13:0] frequency_in = 14'h0064;
    logic [15:0] amplitude_in = 16'h0100, offset_in = 16'h0200;
    logic [15:0] hold_volt_in = 16'h0a00, static_volt_in = 16'h1234;
    logic [15:0] seg_start_in = 16'h0800, seg_end_in = 16'h0800;
    logic [15:0] curr_limit_in = 16'h2000, pow_limit_in = 16'h3000;
    logic [15:0] gen_limit_in = 16'hffff;
    logic [28:0] first_phase_time_in = 29'h2, second_phase_time_in = 29'h2;
    logic [28:0] third_phase_time_in = 29'h2, fourth_phase_time_in = 29'h2;
    logic [28:0] seg_time_in = 29'h2;
    logic dc_on_out, loaded_out, running_out, start_enable_out, alarm_out;
    logic available_out;
    logic [15:0] volt_set_out, curr_set_out, pow_set_out, stage_volt, mn, mx;
    int failures = 0, checks_done = 0;
    swu_top #(.TICK_CYCLES(TK)) uut (.*);
    swu_stage stage (.clk_in(ref_clk_in), .dc_on_in(dc_on_out),
        .volt_in(volt_set_out), .volt_out(stage_volt));
    initial forever #2.5 ref_clk_in = ~ref_clk_in;
    task results;
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task chk(input logic [15:0] a, input logic [15:0] e);
        checks_done++;
        if (a !== e) begin
            failures++;
            $display("ERROR t=%0t got %h exp %h", $time, a, e);
        end
    endtask
    task cmd(input int k);
        @(posedge ref_clk_in);
        case (k)
            0: load_in <= 1'b1;
            1: start_in <= 1'b1;
            2: stop_in <= 1'b1;
            3: onoff_in <= 1'b1;
            default: alarm_clr_in <= 1'b1;
        endcase
        @(posedge ref_clk_in);
        {load_in, start_in, stop_in, onoff_in, alarm_clr_in} <= 5'h00;
        #1;
    endtask
    task watch(input int n);
        mn = 16'hffff;
        mx = 16'h0000;
        repeat (n * TK) begin
            @(posedge ref_clk_in);
            #1;
            if (volt_set_out < mn) mn = volt_set_out;
            if (volt_set_out > mx) mx = volt_set_out;
        end
    endtask
    task sel(input logic [2:0] f);
        @(posedge ref_clk_in);
        func_sel_in <= f;
    endtask
    initial begin
        repeat (60000) @(posedge ref_clk_in);
        failures++;
        results;
    end
    initial begin
        {load_in, start_in, stop_in, onoff_in, alarm_clr_in, target_current_in,
         seg_wr_in, resistance_mode_in, slave_mode_in, unit_alarm_in,
         event_alarm_in, power_limit_trip_in, current_limit_trip_in} = 13'h0;
        repeat (10) @(posedge ref_clk_in);
        sys_rst_in <= 1'b0;
        cmd(1); chk(running_out, 1'b0);
        for (int f = 0; f < 4; f++) begin
            sel(f[2:0]);
            gen_limit_in <= (f == 2) ? 16'h0280 : 16'hffff;
            cmd(0); chk(dc_on_out & loaded_out, 1'b1);
            chk(start_enable_out, 1'b1);
            @(posedge ref_clk_in);
            #1 chk(volt_set_out, static_volt_in);
            cmd(1); chk(running_out, 1'b1);
            watch(2);
            watch(8);
            if (f == 0) chk(mx <= 16'h0300 && mn >= 16'h0100, 1'b1);
            else begin
                chk(mx, f == 2 ? 16'h0280 : 16'h0300);
                chk(mn, 16'h0200);
            end
            if (f[0]) begin
                cmd(2); chk({running_out, dc_on_out}, 2'h1);
                cmd(3);
            end else begin
                cmd(3); chk({running_out, dc_on_out}, 2'h0);
                @(posedge ref_clk_in);
                #1 chk(stage_volt, 16'h0000);
            end
        end
        cmd(0);
        for (int k = 0; k < 4; k++) begin
            cmd(1); chk({running_out, dc_on_out}, 2'h3);
            @(posedge ref_clk_in);
            {unit_alarm_in, power_limit_trip_in, current_limit_trip_in,
             event_alarm_in} <= 4'h8 >> k;
            @(posedge ref_clk_in);
            {unit_alarm_in, power_limit_trip_in, current_limit_trip_in,
             event_alarm_in} <= 4'h0;
            #1 chk({running_out, dc_on_out, alarm_out}, 3'h1);
            cmd(4); chk(alarm_out, 1'b0);
        end
        sel(3'h2);
        target_current_in <= 1'b1;
        cmd(0);
        @(posedge ref_clk_in);
        #1 chk(curr_set_out, 16'h0000);
        cmd(3);
        target_current_in <= 1'b0;
        resistance_mode_in <= 1'b1;
        cmd(0); chk({available_out, loaded_out}, 2'h0);
        resistance_mode_in <= 1'b0;
        slave_mode_in <= 1'b1;
        @(posedge ref_clk_in);
        #1 chk(available_out, 1'b0);
        slave_mode_in <= 1'b0;
        sel(3'h4);
        cmd(0);
        @(posedge ref_clk_in);
        #1 chk(volt_set_out, hold_volt_in);
        cmd(1);
        watch(3); chk(mx, 16'hc000);
        cmd(3);
        for (int s = 0; s < 5; s++) begin
            @(posedge ref_clk_in);
            seg_wr_in <= 1'b1;
            seg_addr_in <= s[2:0];
        end
        @(posedge ref_clk_in);
        seg_wr_in <= 1'b0;
        cycles_in <= 10'h002;
        cmd(0);
        cmd(1);
        watch(16); chk(mn, 16'h0800);
        chk(running_out, 1'b1);
        watch(8);
        chk({running_out, dc_on_out}, 2'h1);
        chk(pow_set_out, pow_limit_in);
        chk(volt_set_out, hold_volt_in);
        results;
    end
endmodule // swu_top_tb
